//--- hw/fhq_bus_cycle.sv
// One asynchronous flash bus cycle: setup, strobe pulse, hold.
// Assumes din is already synchronised to clk by the caller.
`include "fhq_defs.svh"
module fhq_bus_cycle #(
  parameter int SETUP = `FHQ_SETUP_CYC,
  parameter int RPULSE = `FHQ_ACC_CYC + `FHQ_SYNC_CYC,
  parameter int WPULSE = `FHQ_WPULSE_CYC,
  parameter int HOLD = `FHQ_HOLD_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input fhq_pkg::fhq_cyc_s req,
  input wire logic [15:0] din,
  output logic done,
  output logic [15:0] rdata,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [19:0] addr,
  output logic [15:0] dout,
  output logic dout_oe
);
  // Refuse timings the 8-bit phase counter cannot hold
  initial begin
    if (SETUP < 1 || RPULSE < 1 || WPULSE < 1 || HOLD < 1 || RPULSE > 255 || WPULSE > 255 ||
        SETUP > 255 || HOLD > 255) begin
      $error("fhq_bus_cycle: phase length out of range");
    end
  end

  fhq_pkg::fhq_phase_e phase; // Current phase
  logic [7:0] cnt; // Cycles spent in phase
  logic is_wr; // Latched direction

  // Phase sequencing; the strobe only moves after address and data have settled
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase <= fhq_pkg::FHQ_PH_IDLE;
      cnt <= 8'h00;
      is_wr <= 1'b0;
    end else begin
      case (phase)
        fhq_pkg::FHQ_PH_IDLE: begin
          cnt <= 8'h00;
          if (start) begin
            phase <= fhq_pkg::FHQ_PH_SETUP;
            is_wr <= req.wr;
          end
        end
        fhq_pkg::FHQ_PH_SETUP: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(SETUP - 1)) begin
            phase <= fhq_pkg::FHQ_PH_PULSE;
            cnt <= 8'h00;
          end
        end
        fhq_pkg::FHQ_PH_PULSE: begin
          cnt <= cnt + 8'h01;
          if (cnt == (is_wr ? 8'(WPULSE - 1) : 8'(RPULSE - 1))) begin
            phase <= fhq_pkg::FHQ_PH_HOLD;
            cnt <= 8'h00;
          end
        end
        fhq_pkg::FHQ_PH_HOLD: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(HOLD - 1)) begin
            phase <= fhq_pkg::FHQ_PH_IDLE;
          end
        end
        default: phase <= fhq_pkg::FHQ_PH_IDLE;
      endcase
    end
  end

  // Pin drivers; write-enable rises before hold so the device latches on its rising edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= 20'h00000;
      dout <= 16'h0000;
      dout_oe <= 1'b0;
    end else begin
      if (phase == fhq_pkg::FHQ_PH_IDLE && start) begin
        addr <= req.addr;
        dout <= req.data;
        dout_oe <= req.wr;
        ce_n <= 1'b0;
      end else if (phase == fhq_pkg::FHQ_PH_SETUP && cnt == 8'(SETUP - 1)) begin
        oe_n <= is_wr;
        we_n <= !is_wr;
      end else if (phase == fhq_pkg::FHQ_PH_PULSE && cnt == (is_wr ? 8'(WPULSE - 1) : 8'(RPULSE - 1))) begin
        oe_n <= 1'b1;
        we_n <= 1'b1;
      end else if (phase == fhq_pkg::FHQ_PH_HOLD && cnt == 8'(HOLD - 1)) begin
        ce_n <= 1'b1;
        dout_oe <= 1'b0;
      end
    end
  end

  // Read data is sampled in the last strobe cycle, after access time plus sync delay
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (phase == fhq_pkg::FHQ_PH_PULSE && !is_wr && cnt == 8'(RPULSE - 1)) begin
      rdata <= din;
    end
  end

  // Completion pulse at the end of hold
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done <= 1'b0;
    end else begin
      done <= (phase == fhq_pkg::FHQ_PH_HOLD && cnt == 8'(HOLD - 1));
    end
  end
endmodule // fhq_bus_cycle

//--- hw/fhq_defs.svh
// Constants for the flash host sequencer: register map, bit fields, timing.
// Assumes a 250 MHz system clock and a word-mode (x16) flash bus.
`ifndef FHQ_DEFS_SVH
`define FHQ_DEFS_SVH

// Register offsets (byte addresses on the software port)
`define FHQ_REG_CTRL 8'h00
`define FHQ_REG_ADDR 8'h04
`define FHQ_REG_WDATA 8'h08
`define FHQ_REG_STATUS 8'h0c
`define FHQ_REG_RDATA 8'h10
`define FHQ_REG_PIN 8'h14

// Control field: operation code in bits 2:0, write starts it
`define FHQ_CTRL_OP_HI 2
`define FHQ_CTRL_OP_LO 0

// Status bit positions
`define FHQ_ST_BUSY 0
`define FHQ_ST_DONE 1
`define FHQ_ST_FAIL 2
`define FHQ_ST_TMO 3
`define FHQ_ST_MISMATCH 4
`define FHQ_ST_READY 5
`define FHQ_ST_HIDDEN 6

// Pin control: bit 0 holds the flash reset pin low
`define FHQ_PIN_RST 0

// Status word bit positions on the flash data bus
`define FHQ_DQ_POLL 7
`define FHQ_DQ_TOGGLE 6
`define FHQ_DQ_TIMEOUT 5
`define FHQ_DQ_ERASE_TMR 3
`define FHQ_DQ_TOGGLE2 2

// Unlock handshake of a command sequence
`define FHQ_UNLOCK_ADDR1 20'h00555
`define FHQ_UNLOCK_ADDR2 20'h002aa
`define FHQ_UNLOCK_DATA1 16'h00aa
`define FHQ_UNLOCK_DATA2 16'h0055

// Mode command codes tracked by the host
`define FHQ_CMD_HIDDEN_ENTER 16'h0088
`define FHQ_CMD_HIDDEN_EXIT 16'h0090
`define FHQ_CMD_RESET 16'h00f0

// Timing: the figure in ns, then cycles derived at the clock rate
`define FHQ_CLK_NS 4
`define FHQ_T_ACC_NS 70
`define FHQ_T_SETUP_NS 10
`define FHQ_T_WPULSE_NS 40
`define FHQ_T_HOLD_NS 20
`define FHQ_ACC_CYC ((`FHQ_T_ACC_NS + `FHQ_CLK_NS - 1) / `FHQ_CLK_NS)
`define FHQ_SETUP_CYC ((`FHQ_T_SETUP_NS + `FHQ_CLK_NS - 1) / `FHQ_CLK_NS)
`define FHQ_WPULSE_CYC ((`FHQ_T_WPULSE_NS + `FHQ_CLK_NS - 1) / `FHQ_CLK_NS)
`define FHQ_HOLD_CYC ((`FHQ_T_HOLD_NS + `FHQ_CLK_NS - 1) / `FHQ_CLK_NS)
// Two synchroniser stages sit between the data pins and the sample point
`define FHQ_SYNC_CYC 2

`endif

//--- hw/fhq_host.sv
// Host-side sequencer for a parallel NOR flash: command sequences, reads,
// status polling and read-back verification over the flash pins.
// Assumes a word-mode flash, a 250 MHz clk and a pull-up on the ready/busy wire.
//
// Function
// [R1] Device holds one separate 64-Kbyte hidden block
// [R2] Host enters and exits hidden mode by commands
// [R3] Hidden program/erase use ordinary embedded sequences
// [R4] Hidden protect uses logic-high reset pin level
// [R5] Protected hidden block stays protected forever
// [R6] Hidden block sits at top or bottom
// [R7] Query command then reads; reset command leaves
// [R8] Query signature at 10H-12H, pointer at 15H
// [R9] Supply entries: volts and tenths nibble encoding
// [R10] Timeout entries are power-of-two exponents
// [R11] Size entry and x8/x16 interface code
// [R12] Four erase regions: count-1 and size/256
// [R13] Unlock required; erase suspend read and write
// [R14] Protect, unprotect, no burst; program suspend
// [R15] Boot flag 2 bottom, 3 top
// [R16] Status read with ordinary read timing
// [R17] Device self-returns; host verifies by read-back
// [R18] Programming status: poll, toggle, zero bits
// [R19] Erase status: timer bit marks erase start
// [R20] Erase-suspend read returns status or data
// [R21] Time limit exceeded sets timeout bit
// [R22] Done returns data; bits 0,1,4 zero
// [R23] Poll bit inverts data until done
// [R24] Toggle bit flips each read while busy
// [R25] Erase begins 50 us after last command
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`include "fhq_defs.svh"
module fhq_host #(
  parameter int POLL_MAX = 65535 // Toggle-read pairs before giving up
) (
  input wire logic clk,
  input wire logic reset_n,
  // Software port
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  input wire logic ready_busy_in
);
  // Poll count must fit its 17-bit counter
  initial begin
    if (POLL_MAX < 1 || POLL_MAX > 131071) begin
      $error("fhq_host: POLL_MAX out of range");
    end
  end

  fhq_pkg::fhq_state_e state; // Sequencer state
  fhq_pkg::fhq_op_e op; // Operation in progress
  logic [1:0] step; // Position within an operation
  logic [16:0] poll_cnt; // Toggle pairs seen so far
  logic [19:0] addr_reg; // Target address
  logic [15:0] wdata_reg; // Data or command code
  logic [15:0] rdata_reg; // Last data read from flash
  logic [15:0] first_rd; // Earlier read of a toggle pair
  logic done_flag, fail_flag, tmo_flag, mismatch_flag; // Sticky results
  logic hidden_mode; // Host's view of the device mode
  logic pin_rst; // Software-held flash reset
  logic [15:0] dq_meta, dq_sync; // Data pin synchroniser
  logic rb_meta, rb_sync; // Ready/busy synchroniser
  logic cyc_start; // Request pulse to the cycle engine
  fhq_pkg::fhq_cyc_s cyc_req; // Request contents
  logic cyc_done; // Cycle finished
  logic [15:0] cyc_rdata; // Data of the finished read
  logic go; // Start request from software
  logic toggled; // Toggle bit differs between two reads

  assign go = sw_wr && sw_addr == `FHQ_REG_CTRL && state == fhq_pkg::FHQ_IDLE;
  // Busy if the toggle bit moved between consecutive reads [R24]
  assign toggled = first_rd[`FHQ_DQ_TOGGLE] != cyc_rdata[`FHQ_DQ_TOGGLE];

  // Two flip-flops on every pin input; only the second stage is read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end else begin
      dq_meta <= flash_dq_in;
      dq_sync <= dq_meta;
      rb_meta <= ready_busy_in;
      rb_sync <= rb_meta;
    end
  end

  // Status is read with ordinary read timing, so one engine serves all cycles [R16]
  fhq_bus_cycle u_cycle (
    .clk(clk),
    .reset_n(reset_n),
    .start(cyc_start),
    .req(cyc_req),
    .din(dq_sync),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .ce_n(flash_ce_n),
    .oe_n(flash_oe_n),
    .we_n(flash_we_n),
    .addr(flash_addr),
    .dout(flash_dq_out),
    .dout_oe(flash_dq_oe)
  );

  // Software-written settings
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
      pin_rst <= 1'b0;
    end else if (sw_wr) begin
      case (sw_addr)
        `FHQ_REG_ADDR: addr_reg <= sw_wdata[19:0];
        `FHQ_REG_WDATA: wdata_reg <= sw_wdata[15:0];
        `FHQ_REG_PIN: pin_rst <= sw_wdata[`FHQ_PIN_RST];
        default: ;
      endcase
    end
  end

  // Reset pin sits at logic high unless software asks for a hardware reset or the host itself is in reset;
  // the host never raises it above that level, so hidden protect is as required [R4]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flash_reset_n <= 1'b0;
    end else begin
      flash_reset_n <= !pin_rst;
    end
  end

  // Cycle request builder
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cyc_start <= 1'b0;
      cyc_req <= '0;
    end else begin
      cyc_start <= (state == fhq_pkg::FHQ_ISSUE);
      if (state == fhq_pkg::FHQ_ISSUE) begin
        cyc_req.wr <= (op == fhq_pkg::FHQ_OP_WRITE || op == fhq_pkg::FHQ_OP_SEQ);
        cyc_req.addr <= addr_reg;
        cyc_req.data <= wdata_reg;
        if (op == fhq_pkg::FHQ_OP_SEQ) begin
          // Two unlock writes, then the command code
          case (step)
            2'h0: begin
              cyc_req.addr <= `FHQ_UNLOCK_ADDR1;
              cyc_req.data <= `FHQ_UNLOCK_DATA1;
            end
            2'h1: begin
              cyc_req.addr <= `FHQ_UNLOCK_ADDR2;
              cyc_req.data <= `FHQ_UNLOCK_DATA2;
            end
            default: begin
              cyc_req.addr <= `FHQ_UNLOCK_ADDR1;
              cyc_req.data <= wdata_reg;
            end
          endcase
        end
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= fhq_pkg::FHQ_IDLE;
      op <= fhq_pkg::FHQ_OP_WRITE;
      step <= 2'h0;
      poll_cnt <= 17'h00000;
      first_rd <= 16'h0000;
    end else begin
      case (state)
        fhq_pkg::FHQ_IDLE: begin
          if (go) begin
            op <= fhq_pkg::fhq_op_e'(sw_wdata[`FHQ_CTRL_OP_HI:`FHQ_CTRL_OP_LO]);
            step <= 2'h0;
            poll_cnt <= 17'h00000;
            state <= fhq_pkg::FHQ_ISSUE;
          end
        end
        fhq_pkg::FHQ_ISSUE: state <= fhq_pkg::FHQ_WAIT;
        fhq_pkg::FHQ_WAIT: begin
          if (cyc_done) begin
            state <= fhq_pkg::FHQ_IDLE;
            case (op)
              fhq_pkg::FHQ_OP_SEQ: begin
                if (step != 2'h2) begin
                  step <= step + 2'h1;
                  state <= fhq_pkg::FHQ_ISSUE;
                end
              end
              fhq_pkg::FHQ_OP_POLL: begin
                first_rd <= cyc_rdata;
                if (step == 2'h0 || step == 2'h2) begin
                  // First read of a pair
                  step <= step + 2'h1;
                  state <= fhq_pkg::FHQ_ISSUE;
                end else if (step == 2'h1 && toggled && poll_cnt != 17'(POLL_MAX - 1)) begin
                  poll_cnt <= poll_cnt + 17'h00001;
                  // Timeout seen: one more pair decides pass or fail [R21]
                  step <= cyc_rdata[`FHQ_DQ_TIMEOUT] ? 2'h2 : 2'h1;
                  state <= fhq_pkg::FHQ_ISSUE;
                end
              end
              default: ;
            endcase
          end
        end
        default: state <= fhq_pkg::FHQ_IDLE;
      endcase
    end
  end

  // Result flags; a new start clears them, and completion can't meet a start
  // because starts are refused while busy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      tmo_flag <= 1'b0;
      mismatch_flag <= 1'b0;
      rdata_reg <= 16'h0000;
    end else if (go) begin
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      tmo_flag <= 1'b0;
      mismatch_flag <= 1'b0;
    end else if (state == fhq_pkg::FHQ_WAIT && cyc_done) begin
      if (op == fhq_pkg::FHQ_OP_READ || op == fhq_pkg::FHQ_OP_VERIFY || op == fhq_pkg::FHQ_OP_POLL) begin
        rdata_reg <= cyc_rdata;
      end
      if (op == fhq_pkg::FHQ_OP_WRITE || op == fhq_pkg::FHQ_OP_READ || (op == fhq_pkg::FHQ_OP_SEQ && step == 2'h2)) begin
        done_flag <= 1'b1;
      end
      // Confirm the operation by comparing read-back with the intended data [R17]
      if (op == fhq_pkg::FHQ_OP_VERIFY) begin
        done_flag <= 1'b1;
        mismatch_flag <= (cyc_rdata != wdata_reg);
        fail_flag <= (cyc_rdata != wdata_reg);
      end
      if (op == fhq_pkg::FHQ_OP_POLL && step == 2'h1) begin
        if (!toggled) begin
          done_flag <= 1'b1; // Toggling stopped: device back in read mode [R17]
        end else if (!cyc_rdata[`FHQ_DQ_TIMEOUT] && poll_cnt == 17'(POLL_MAX - 1)) begin
          done_flag <= 1'b1;
          fail_flag <= 1'b1; // Gave up waiting
        end
      end
      if (op == fhq_pkg::FHQ_OP_POLL && step == 2'h3) begin
        done_flag <= 1'b1;
        // Still toggling after timeout: operation failed [R21]
        fail_flag <= toggled;
        tmo_flag <= toggled;
      end
    end
  end

  // Mode tracking: entry and exit commands move hidden mode; reset also leaves it [R2]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hidden_mode <= 1'b0;
    end else if (!flash_reset_n) begin
      hidden_mode <= 1'b0;
    end else if (state == fhq_pkg::FHQ_WAIT && cyc_done && op == fhq_pkg::FHQ_OP_SEQ && step == 2'h2) begin
      if (wdata_reg == `FHQ_CMD_HIDDEN_ENTER) begin
        hidden_mode <= 1'b1; // [R2]
      end else if (wdata_reg == `FHQ_CMD_HIDDEN_EXIT || wdata_reg == `FHQ_CMD_RESET) begin
        hidden_mode <= 1'b0; // [R2] [R7]
      end
    end
  end

  // Read data one cycle after the read strobe; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sw_rdata <= 32'h00000000;
    end else if (sw_rd) begin
      case (sw_addr)
        `FHQ_REG_ADDR: sw_rdata <= {12'h000, addr_reg};
        `FHQ_REG_WDATA: sw_rdata <= {16'h0000, wdata_reg};
        `FHQ_REG_STATUS: sw_rdata <= {25'h0000000, hidden_mode, rb_sync, mismatch_flag, tmo_flag, fail_flag,
                                      done_flag, state != fhq_pkg::FHQ_IDLE};
        `FHQ_REG_RDATA: sw_rdata <= {16'h0000, rdata_reg};
        `FHQ_REG_PIN: sw_rdata <= {31'h00000000, pin_rst};
        default: sw_rdata <= 32'h00000000;
      endcase
    end else begin
      sw_rdata <= 32'h00000000;
    end
  end
endmodule // fhq_host

//--- hw/fhq_pkg.sv
// Types shared by the flash host sequencer and its bus-cycle engine.
// Assumes fhq_defs.svh holds all numeric constants.
package fhq_pkg;
  // One flash bus cycle request
  typedef struct packed {
    logic wr;
    logic [19:0] addr;
    logic [15:0] data;
  } fhq_cyc_s;

  // Operations that software may start
  typedef enum logic [2:0] {
    FHQ_OP_WRITE = 3'h0,
    FHQ_OP_READ = 3'h1,
    FHQ_OP_SEQ = 3'h2,
    FHQ_OP_POLL = 3'h3,
    FHQ_OP_VERIFY = 3'h4
  } fhq_op_e;

  // Sequencer states
  typedef enum {FHQ_IDLE, FHQ_ISSUE, FHQ_WAIT} fhq_state_e;

  // Bus-cycle engine phases
  typedef enum {FHQ_PH_IDLE, FHQ_PH_SETUP, FHQ_PH_PULSE, FHQ_PH_HOLD} fhq_phase_e;
endpackage

//--- verif/fhq_flash_model.sv
// Behavioural word-mode NOR flash seen by the host sequencer.
// Assumes the bench resolves the data bus and pulls the ready wire up.
module fhq_flash_model #(
  parameter int BUSY_READS = 4, // Status reads before a program ends
  parameter logic [15:0] QUERY_CMD = 16'h0098, // Query entry code
  parameter logic [15:0] PROG_CMD = 16'h00a0, // Program setup code
  parameter logic [15:0] SET_CODE = 16'h0007, // Command-set code, arbitrary
  parameter logic [15:0] BOOT_FLAG = 16'h0002 // Bottom-boot flavour
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  input wire logic [19:0] addr,
  input wire logic [15:0] din,
  input wire logic [1:0] fail_mode, // 0 normal, 1 time limit, 2 never ends
  output logic [15:0] dout,
  output logic busy_low // Pull-down on the open-drain wire
);
  int unsigned step = 0; // Unlock progress
  int unsigned busy = 0; // Reads left in the operation
  logic query = 1'b0, hidden = 1'b0, armed = 1'b0, tmo = 1'b0, tog = 1'b0, pvalid = 1'b0;
  logic [19:0] paddr = '0;
  logic [15:0] pdata = '0;
  assign busy_low = (busy != 0) || tmo;
  // Query table; unlisted places read zero
  function automatic logic [15:0] cfi(input logic [6:0] a);
    case (a)
      7'h10: return 16'h0051;
      7'h11: return 16'h0052;
      7'h12: return 16'h0059;
      7'h13: return SET_CODE;
      7'h15, 7'h2f: return 16'h0040;
      7'h1b: return 16'h0027;
      7'h1c: return 16'h0036;
      7'h1f, 7'h25, 7'h2c, 7'h49: return 16'h0004;
      7'h21: return 16'h000a;
      7'h23: return 16'h0005;
      7'h27: return 16'h0015;
      7'h28, 7'h46: return 16'h0002;
      7'h47, 7'h48, 7'h50: return 16'h0001;
      7'h4f: return BOOT_FLAG;
      default: return 16'h0000;
    endcase
  endfunction
  // Commands take effect on the closing write-enable edge
  always @(posedge we_n) begin
    if (!ce_n) begin
      if (armed) begin
        armed = 1'b0;
        paddr = addr;
        pdata = din;
        busy = (fail_mode == 2'd2) ? 32'hffff_ffff : BUSY_READS;
        tmo = (fail_mode == 2'd1);
      end else if (din == 16'h00f0) begin // Reset command
        if (tmo) busy = 0;
        tmo = 1'b0;
        query = 1'b0;
        step = 0;
      end else if (busy != 0) begin
        step = 0; // Ignored while working
      end else if (step == 2) begin
        step = 0;
        if (din == 16'h0088) hidden = 1'b1;
        if (din == 16'h0090) hidden = 1'b0;
        if (din == QUERY_CMD) query = 1'b1;
        if (din == PROG_CMD) armed = 1'b1;
      end else if (din == 16'h0055 && addr == 20'h002aa && step == 1) begin
        step = 2;
      end else begin
        step = (din == 16'h00aa && addr == 20'h00555) ? 1 : 0;
      end
    end
  end
  // One word per output-enable access with chip enable low
  always @(negedge oe_n) begin
    if (!ce_n) begin
      if (busy != 0 || tmo) begin
        tog = ~tog;
        dout = {8'h00, ~pdata[7], tog, tmo, 5'b00100};
        if (!tmo && busy != 32'hffff_ffff) busy = busy - 1;
        if (busy == 0 && !tmo) pvalid = 1'b1;
      end else if (query) dout = cfi(addr[6:0]);
      else if (pvalid && addr == paddr) dout = pdata;
      else if (hidden && addr < 20'h08000) dout = 16'hc3c3 ^ addr[15:0];
      else dout = addr[15:0] ^ 16'h5a5a;
    end
  end
  // Released bus must not keep showing the last word
  always @(posedge oe_n) dout = ~dout;
  // Hardware reset ends every mode and operation
  always @(negedge rst_n) begin
    {query, hidden, armed, tmo} = 4'h0;
    busy = 0;
    step = 0;
  end
endmodule // fhq_flash_model

//--- verif/fhq_host_sva.sv
// Port checks on the flash host sequencer: bus-cycle shape and register port.
// Assumes it is bound into fhq_host and that one clock drives everything.
`include "fhq_defs.svh"
module fhq_host_sva #(
  parameter int POLL_MAX = 4 // Same poll limit as the sequencer
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n,
  input wire logic flash_dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] oe_low; // Cycles of the current read strobe
  logic [7:0] we_low; // Cycles of the current write strobe
  // Strobe length counter; too many cycles for a repetition
  always_ff @(posedge clk) begin
    if (!reset_n || flash_oe_n) begin
      oe_low <= 8'h00;
    end else begin
      oe_low <= oe_low + 8'h01;
    end
  end
  // Write strobe length counter, checked when the strobe rises
  always_ff @(posedge clk) begin
    if (!reset_n || flash_we_n) begin
      we_low <= 8'h00;
    end else begin
      we_low <= we_low + 8'h01;
    end
  end
  sequence s_ce_hold;
    !flash_ce_n [*5] ##1 flash_ce_n;
  endsequence
  a_rdata_slot: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0) else $error("stray read data");
  a_strobe_excl: assert property (flash_oe_n || flash_we_n) else $error("both strobes low");
  a_strobe_in_ce: assert property (!flash_oe_n || !flash_we_n |-> !flash_ce_n) else $error("strobe w/o ce");
  a_drive_write: assert property (!flash_we_n |-> flash_dq_oe) else $error("write not driven");
  a_release_read: assert property (!flash_oe_n |-> !flash_dq_oe) else $error("bus fight on read");
  a_we_setup: assert property ($fell(flash_we_n) |-> $past(flash_ce_n, 3) == 1'b0 &&
    $past(flash_ce_n, 4) == 1'b1) else $error("write setup wrong");
  a_we_pulse: assert property ($rose(flash_we_n) |-> we_low == 8'h0a) else $error("write pulse wrong");
  a_we_hold: assert property ($rose(flash_we_n) |-> s_ce_hold) else $error("write hold wrong");
  a_oe_pulse: assert property ($rose(flash_oe_n) |-> oe_low == 8'h14) else $error("read pulse wrong");
  a_pin_reset: assert property (sw_wr && sw_addr == `FHQ_REG_PIN && sw_wdata[0] |-> ##[1:2] !flash_reset_n)
    else $error("reset pin not low");
endmodule // fhq_host_sva

bind fhq_host fhq_host_sva #(.POLL_MAX(POLL_MAX)) u_sva (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr),
  .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n), .flash_dq_oe(flash_dq_oe));

//--- verif/test_flash_hidden_area_query_status.sv
// Self-checking bench: flash host sequencer driving the flash model.
// Assumes the register map of fhq_defs.svh and a 250 MHz clock.
`include "fhq_defs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_flash_hidden_area_query_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, rd_val;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_dq_oe, busy_low;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_out, model_dq;
  logic [1:0] fail_mode = 2'd0; // Fault the model should show
  int miscompares = 0, checks_done = 0;
  wire logic [15:0] flash_dq_in = flash_dq_oe ? flash_dq_out : model_dq; // Bus owner
  wire logic ready_busy_in = !busy_low; // Pull-up unless pulled low
  // Query rows: table place, expected word
  localparam logic [23:0] ROWS [16] = '{24'h10_0051, 24'h11_0052, 24'h12_0059, 24'h15_0040, 24'h1b_0027,
    24'h1f_0004, 24'h21_000a, 24'h23_0005, 24'h25_0004, 24'h27_0015, 24'h28_0002, 24'h2c_0004, 24'h2f_0040,
    24'h46_0002, 24'h4f_0002, 24'h50_0001};
  fhq_host #(.POLL_MAX(4)) dut (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .ready_busy_in(ready_busy_in));
  fhq_flash_model flash (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .rst_n(flash_reset_n),
    .addr(flash_addr), .din(flash_dq_out), .fail_mode(fail_mode), .dout(model_dq), .busy_low(busy_low));
  // 4 ns clock
  initial forever #2 clk = ~clk;
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  // Register read; data stand only in the next cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 rd_val = sw_rdata;
  endtask
  // Start an operation, then poll busy under a bound
  task automatic op(input logic [2:0] code);
    wr(`FHQ_REG_CTRL, {29'h0, code});
    for (int i = 0; i < 400; i++) begin
      rd(`FHQ_REG_STATUS);
      if (rd_val[`FHQ_ST_BUSY] === 1'b0) break;
    end
    `CHK(rd_val[`FHQ_ST_BUSY], 1'b0)
  endtask
  // Unlocked command sequence
  task automatic cmd(input logic [15:0] c);
    wr(`FHQ_REG_WDATA, {16'h0, c});
    op(3'h2);
  endtask
  task automatic st(input logic [31:0] mask, input logic [31:0] exp);
    rd(`FHQ_REG_STATUS);
    `CHK(rd_val & mask, exp)
  endtask
  // Program one word at a place; the model decides how it ends
  task automatic prog(input logic [19:0] a, input logic [15:0] d);
    cmd(16'h00a0);
    wr(`FHQ_REG_ADDR, {12'h0, a});
    wr(`FHQ_REG_WDATA, {16'h0, d});
    op(3'h0);
    st(32'h20, 32'h0);
    op(3'h3);
  endtask
  task automatic summarize();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, far above the expected run
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    cmd(16'h0098);
    // Every row goes through a real flash read
    foreach (ROWS[i]) begin
      wr(`FHQ_REG_ADDR, {24'h0, ROWS[i][23:16]});
      op(3'h1);
      rd(`FHQ_REG_RDATA);
      `CHK(rd_val, {16'h0, ROWS[i][15:0]})
    end
    cmd(16'h00f0);
    op(3'h1);
    rd(`FHQ_REG_RDATA);
    `CHK(rd_val, 32'h0000_5a0a)
    cmd(16'h0088);
    op(3'h1);
    rd(`FHQ_REG_RDATA);
    `CHK(rd_val, 32'h0000_c393)
    st(32'h40, 32'h40);
    cmd(16'h0090);
    st(32'h40, 32'h0);
    // Good program, then verify both ways
    prog(20'h00123, 16'h1234);
    st(32'h3c, 32'h20);
    op(3'h4);
    st(32'h10, 32'h0);
    wr(`FHQ_REG_WDATA, 32'h0000_1235);
    op(3'h4);
    st(32'h10, 32'h10);
    // Time limit, cleared by the reset command
    fail_mode <= 2'd1;
    prog(20'h00200, 16'h00ff);
    st(32'h2c, 32'h0c);
    cmd(16'h00f0);
    st(32'h20, 32'h20);
    // Never-ending operation in hidden mode; pin reset recovers
    fail_mode <= 2'd2;
    cmd(16'h0088);
    prog(20'h00300, 16'h5555);
    st(32'h6c, 32'h44);
    wr(`FHQ_REG_PIN, 32'h1);
    wr(`FHQ_REG_PIN, 32'h0);
    fail_mode <= 2'd0;
    st(32'h60, 32'h20);
    // Second reset in mid-run
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    st(32'hff, 32'h20);
    summarize();
  end
endmodule // test_flash_hidden_area_query_status
